// ### rtl/exec_core.sv
// Decode and execute for the literal, logic, rotate, subtract and return opcodes
`timescale 1ns/1ns
module exec_core
	import exec_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Instruction issue
	input wire logic insn_valid,
	input wire logic [13:0] insn,
	// File register read data for the addressed register
	input wire logic [7:0] file_rdata,
	// Return stack top
	input wire logic [12:0] stack_top,
	// File register write
	output logic [6:0] file_addr,
	output logic file_we,
	output logic [7:0] file_wdata,
	// Accumulator and status flags
	output logic [7:0] acc,
	output logic carry_flag,
	output logic nibble_wrap_flag,
	output logic zero_flag,
	output logic timeout_flag,
	output logic sleep_entered_flag,
	// Program flow
	output logic stack_pop,
	output logic pc_load,
	output logic [12:0] pc_value,
	output logic busy,
	output logic halted,
	// Watchdog control
	output logic watchdog_clear
);
	// -----------------------------------------------------------------
	// Decode
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_SECOND = 2'b10
	} state_t;

	state_t state;
	state_t next_state;

	wire [5:0] top6 = insn[13:8];
	wire [5:0] lit4 = {top6[5:2], 2'b00};
	wire [5:0] lit5 = {top6[5:1], 1'b0};
	wire dest_file = insn[7];
	wire [7:0] imm = insn[7:0];
	wire go = insn_valid && (state == ST_RUN) && !halted;

	// Opcode decode wires; load and return ignore the two don't-care bits
	wire is_load_lit = go && (lit4 == OPC_LOAD_LIT);
	wire is_ret_lit = go && (lit4 == OPC_RET_LIT);
	wire is_or_lit = go && (top6 == OPC_OR_LIT); // Full match; neighbour 6'h39 is no-operation, neighbour 6'h37 decodes as return literal
	wire is_xor_lit = go && (top6 == OPC_XOR_LIT); // Full match, neighbour codes are no-operation
	wire is_sub_lit = go && (lit5 == OPC_SUB_LIT);
	wire is_store = go && (top6 == OPC_STORE) && insn[7];
	wire is_sub_f = go && (top6 == OPC_SUB_F);
	wire is_or_f = go && (top6 == OPC_OR_F);
	wire is_xor_f = go && (top6 == OPC_XOR_F);
	wire is_rrf = go && (top6 == OPC_RRF);
	wire is_rlf = go && (top6 == OPC_RLF);
	wire is_swap = go && (top6 == OPC_SWAP);
	wire is_return = go && (insn == OPC_RETURN);
	wire is_sleep = go && (insn == OPC_SLEEP);

	wire is_lit_alu = is_or_lit || is_xor_lit || is_sub_lit;
	wire is_file_alu = is_or_f || is_xor_f || is_sub_f || is_rrf || is_rlf || is_swap;
	wire is_two_cycle = is_ret_lit || is_return;

	// -----------------------------------------------------------------
	// Datapath
	// -----------------------------------------------------------------
	wire [7:0] alu_opa = is_lit_alu ? imm : file_rdata;
	wire [7:0] alu_res;
	wire alu_c;
	wire alu_dc;
	wire alu_z;

	exec_alu u_alu (
		.sel_or(is_or_lit || is_or_f),
		.sel_xor(is_xor_lit || is_xor_f),
		.sel_sub(is_sub_lit || is_sub_f),
		.sel_rlf(is_rlf),
		.sel_rrf(is_rrf),
		.sel_swap(is_swap),
		.sel_pass(1'b0),
		.opa(alu_opa),
		.acc(acc),
		.carry_in(carry_flag),
		.result(alu_res),
		.carry_out(alu_c),
		.nibble_out(alu_dc),
		.zero_out(alu_z)
	);

	// Destination steering and flag update enables
	wire to_file = (is_file_alu && dest_file) || is_store;
	wire to_acc = is_lit_alu || (is_file_alu && !dest_file);
	wire upd_z = is_or_lit || is_xor_lit || is_sub_lit || is_or_f || is_xor_f || is_sub_f;
	wire upd_c = is_sub_lit || is_sub_f || is_rlf || is_rrf;
	wire upd_dc = is_sub_lit || is_sub_f;

	wire [7:0] next_acc = is_load_lit || is_ret_lit ? imm : (to_acc ? alu_res : acc);
	wire [7:0] next_wdata = is_store ? acc : alu_res;

	// -----------------------------------------------------------------
	// Sequencer: two-cycle returns spend their second cycle as a bubble
	// -----------------------------------------------------------------
	always_comb begin
		case (state)
			ST_RUN: next_state = is_two_cycle ? ST_SECOND : ST_RUN;
			ST_SECOND: next_state = ST_RUN;
			default: next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Accumulator and arithmetic flags
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			acc <= ACC_RST;
			carry_flag <= 1'b0;
			nibble_wrap_flag <= 1'b0;
			zero_flag <= 1'b0;
		end else begin
			acc <= next_acc;
			if (upd_c) begin
				carry_flag <= alu_c;
			end
			if (upd_dc) begin
				nibble_wrap_flag <= alu_dc;
			end
			if (upd_z) begin
				zero_flag <= alu_z;
			end
		end
	end

	// File write port, registered so the write lands one cycle after issue
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			file_we <= 1'b0;
			file_addr <= 7'h00;
			file_wdata <= 8'h00;
		end else begin
			file_we <= to_file;
			file_addr <= insn[6:0];
			file_wdata <= next_wdata;
		end
	end

	// Return handling: pop and load the program counter from the stack top
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stack_pop <= 1'b0;
			pc_load <= 1'b0;
			pc_value <= PC_RST;
			busy <= 1'b0;
		end else begin
			stack_pop <= is_two_cycle;
			pc_load <= is_two_cycle;
			if (is_two_cycle) begin
				pc_value <= stack_top;
			end
			busy <= is_two_cycle;
		end
	end

	// Low-power entry; the halt holds until reset since wake logic lives elsewhere
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			timeout_flag <= 1'b1;
			sleep_entered_flag <= 1'b1;
			halted <= 1'b0;
			watchdog_clear <= 1'b0;
		end else begin
			watchdog_clear <= is_sleep;
			if (is_sleep) begin
				timeout_flag <= 1'b1;
				sleep_entered_flag <= 1'b0;
				halted <= 1'b1;
			end
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	a_load_literal: assert property (@(posedge mclk) disable iff (!arst_n)
		is_load_lit |=> (acc == $past(imm)) && $stable(zero_flag) && $stable(carry_flag))
		else $error("load literal wrong");
	a_ret_two_cycle: assert property (@(posedge mclk) disable iff (!arst_n)
		is_ret_lit |=> pc_load && busy && (acc == $past(imm)) ##1 !busy)
		else $error("return literal wrong");
	a_return_pop: assert property (@(posedge mclk) disable iff (!arst_n)
		is_return |=> stack_pop && (pc_value == $past(stack_top)) && $stable(zero_flag))
		else $error("return pop wrong");
	a_dest_select: assert property (@(posedge mclk) disable iff (!arst_n)
		(is_file_alu && dest_file) |=> file_we && (acc == $past(acc)))
		else $error("destination wrong");
	a_rotate_left: assert property (@(posedge mclk) disable iff (!arst_n)
		(is_rlf && !dest_file) |=> acc == {$past(file_rdata[6:0]), $past(carry_flag)})
		else $error("rotate left wrong");
	a_rotate_right: assert property (@(posedge mclk) disable iff (!arst_n)
		is_rrf |=> carry_flag == $past(file_rdata[0]))
		else $error("rotate right wrong");
	a_sleep_flags: assert property (@(posedge mclk) disable iff (!arst_n)
		is_sleep |=> timeout_flag && !sleep_entered_flag && halted && watchdog_clear)
		else $error("sleep entry wrong");
	a_sub_borrow: assert property (@(posedge mclk) disable iff (!arst_n)
		is_sub_lit |=> carry_flag == ($past(imm) >= $past(acc)))
		else $error("subtract carry wrong");
	a_zero_flag: assert property (@(posedge mclk) disable iff (!arst_n)
		(is_xor_lit) |=> zero_flag == ($past(imm) == $past(acc)))
		else $error("zero flag wrong");

	// -----------------------------------------------------------------
	// Logic and subtract checks
	// -----------------------------------------------------------------
	a_or_literal: assert property (@(posedge mclk) disable iff (!arst_n)
		is_or_lit |=> (acc == ($past(imm) | $past(acc))) && $stable(carry_flag))
		else $error("or literal wrong");
	a_or_file: assert property (@(posedge mclk) disable iff (!arst_n)
		(is_or_f && !dest_file) |=> acc == ($past(file_rdata) | $past(acc)))
		else $error("or file to acc wrong");
	a_or_file_write: assert property (@(posedge mclk) disable iff (!arst_n)
		(is_or_f && dest_file) |=> file_wdata == ($past(file_rdata) | $past(acc)))
		else $error("or file write wrong");
	a_dest_acc: assert property (@(posedge mclk) disable iff (!arst_n)
		(is_file_alu && !dest_file) |=> !file_we)
		else $error("acc destination wrote file");
	a_file_addr: assert property (@(posedge mclk) disable iff (!arst_n)
		(is_file_alu && dest_file) |=> file_addr == $past(insn[6:0]))
		else $error("file address wrong");
	a_sub_literal: assert property (@(posedge mclk) disable iff (!arst_n)
		is_sub_lit |=> (acc == 8'($past(imm) - $past(acc)))
			&& (nibble_wrap_flag == ($past(imm[3:0]) >= $past(acc[3:0]))))
		else $error("literal subtract wrong");
	a_sub_file: assert property (@(posedge mclk) disable iff (!arst_n)
		(is_sub_f && dest_file) |=> file_we && (file_wdata == 8'($past(file_rdata) - $past(acc))))
		else $error("file subtract wrong");
	a_sub_file_flags: assert property (@(posedge mclk) disable iff (!arst_n)
		is_sub_f |=> (carry_flag == ($past(file_rdata) >= $past(acc)))
			&& (nibble_wrap_flag == ($past(file_rdata[3:0]) >= $past(acc[3:0]))))
		else $error("file subtract flags wrong");
	a_zero_sub: assert property (@(posedge mclk) disable iff (!arst_n)
		is_sub_f |=> zero_flag == ($past(file_rdata) == $past(acc)))
		else $error("subtract zero wrong");
	a_xor_literal: assert property (@(posedge mclk) disable iff (!arst_n)
		is_xor_lit |=> (acc == ($past(imm) ^ $past(acc))) && $stable(carry_flag))
		else $error("xor literal wrong");
	a_xor_file: assert property (@(posedge mclk) disable iff (!arst_n)
		(is_xor_f && dest_file) |=> file_we && (file_wdata == ($past(file_rdata) ^ $past(acc))))
		else $error("xor file wrong");

	// -----------------------------------------------------------------
	// Rotate, exchange and store checks
	// -----------------------------------------------------------------
	a_swap_nibbles: assert property (@(posedge mclk) disable iff (!arst_n)
		(is_swap && !dest_file) |=> (acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
			&& $stable(carry_flag) && $stable(zero_flag))
		else $error("nibble exchange wrong");
	a_rotate_right_data: assert property (@(posedge mclk) disable iff (!arst_n)
		(is_rrf && !dest_file) |=> (acc == {$past(carry_flag), $past(file_rdata[7:1])})
			&& $stable(zero_flag))
		else $error("rotate right data wrong");
	a_rotate_left_carry: assert property (@(posedge mclk) disable iff (!arst_n)
		is_rlf |=> carry_flag == $past(file_rdata[7]))
		else $error("rotate left carry wrong");
	a_store_acc: assert property (@(posedge mclk) disable iff (!arst_n)
		is_store |=> file_we && (file_wdata == $past(acc)) && $stable(zero_flag))
		else $error("store wrong");
	a_nop_idle: assert property (@(posedge mclk) disable iff (!arst_n)
		(go && (top6 == OPC_STORE) && !dest_file && !is_return && !is_sleep)
			|=> !file_we && (acc == $past(acc)) && $stable(zero_flag))
		else $error("no-operation changed state");

	// -----------------------------------------------------------------
	// Flow and low-power checks
	// -----------------------------------------------------------------
	a_ret_no_flags: assert property (@(posedge mclk) disable iff (!arst_n)
		is_ret_lit |=> $stable(zero_flag) && $stable(carry_flag) && $stable(nibble_wrap_flag))
		else $error("return literal touched flags");
	a_busy_refuse: assert property (@(posedge mclk) disable iff (!arst_n)
		(busy && insn_valid) |=> $stable(acc) && !file_we && !pc_load)
		else $error("word taken in dead cycle");
	a_halt_holds: assert property (@(posedge mclk) disable iff (!arst_n)
		halted |=> halted && $stable(acc) && !file_we)
		else $error("halted core executed");
	a_wd_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
		watchdog_clear |=> !watchdog_clear)
		else $error("watchdog clear not a pulse");

	// Main scenarios reached
	c_ret_lit: cover property (@(posedge mclk) disable iff (!arst_n) is_ret_lit);
	c_sub_borrow: cover property (@(posedge mclk) disable iff (!arst_n) is_sub_f && !alu_c);
	c_sleep: cover property (@(posedge mclk) disable iff (!arst_n) is_sleep);
	c_file_dest: cover property (@(posedge mclk) disable iff (!arst_n) is_file_alu && dest_file);
	c_busy_drop: cover property (@(posedge mclk) disable iff (!arst_n) busy && insn_valid);
endmodule

// ### rtl/exec_pkg.sv
// Constants and opcode encodings for the partial execute unit
package exec_pkg;
	localparam int INSN_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int PC_W = 13;
	// Upper six opcode bits of literal forms
	localparam logic [5:0] OPC_LOAD_LIT = 6'h30; // 11 00xx, low two bits masked
	localparam logic [5:0] OPC_RET_LIT = 6'h34; // 11 01xx, low two bits masked
	localparam logic [5:0] OPC_OR_LIT = 6'h38;
	localparam logic [5:0] OPC_XOR_LIT = 6'h3a;
	localparam logic [5:0] OPC_SUB_LIT = 6'h3c; // 11 110x
	// Upper six opcode bits of file forms
	localparam logic [5:0] OPC_STORE = 6'h00; // with bit 7 set
	localparam logic [5:0] OPC_SUB_F = 6'h02;
	localparam logic [5:0] OPC_OR_F = 6'h04;
	localparam logic [5:0] OPC_XOR_F = 6'h06;
	localparam logic [5:0] OPC_RRF = 6'h0c;
	localparam logic [5:0] OPC_RLF = 6'h0d;
	localparam logic [5:0] OPC_SWAP = 6'h0e;
	// Whole-word control opcodes
	localparam logic [13:0] OPC_RETURN = 14'h0008;
	localparam logic [13:0] OPC_SLEEP = 14'h0063;
	// Reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [12:0] PC_RST = 13'h0000;
endpackage

// ### rtl/exec_alu.sv
// Combinational result and flag unit for the execute block
`timescale 1ns/1ns
module exec_alu
	import exec_pkg::*;
(
	// Operation select
	input wire logic sel_or,
	input wire logic sel_xor,
	input wire logic sel_sub,
	input wire logic sel_rlf,
	input wire logic sel_rrf,
	input wire logic sel_swap,
	input wire logic sel_pass,
	// Operands
	input wire logic [7:0] opa,
	input wire logic [7:0] acc,
	input wire logic carry_in,
	// Results
	output logic [7:0] result,
	output logic carry_out,
	output logic nibble_out,
	output logic zero_out
);
	// Subtract as opa plus inverted acc plus one; carry is the no-borrow sense
	wire [8:0] diff = {1'b0, opa} + {1'b0, ~acc} + 9'h001;
	wire [4:0] ldiff = {1'b0, opa[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

	// Result selection
	always_comb begin
		result = opa;
		carry_out = carry_in;
		if (sel_or) begin
			result = opa | acc;
		end else if (sel_xor) begin
			result = opa ^ acc;
		end else if (sel_sub) begin
			result = diff[7:0];
			carry_out = diff[8];
		end else if (sel_rlf) begin
			result = {opa[6:0], carry_in};
			carry_out = opa[7];
		end else if (sel_rrf) begin
			result = {carry_in, opa[7:1]};
			carry_out = opa[0];
		end else if (sel_swap) begin
			result = {opa[3:0], opa[7:4]};
		end else if (sel_pass) begin
			result = opa;
		end
	end

	assign nibble_out = ldiff[4];
	assign zero_out = (result == 8'h00);
endmodule

// ### bench/mcu_instruction_execute_part_test.sv
// Self-checking bench for the partial execute unit
`timescale 1ns/1ns
module mcu_instruction_execute_part_test;
	import exec_pkg::*;
	// ----------------------------------------
	// Stimulus, outputs and bench state
	// ----------------------------------------
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic insn_valid = 1'b0;
	logic [13:0] insn = 14'h0000;
	logic [7:0] file_rdata = 8'h00;
	logic [12:0] stack_top = 13'h0000;
	logic [6:0] file_addr;
	logic [7:0] file_wdata, acc;
	logic [12:0] pc_value;
	logic file_we, carry_flag, nibble_wrap_flag, zero_flag, timeout_flag, sleep_entered_flag;
	logic stack_pop, pc_load, busy, halted, watchdog_clear;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	// Bench copy of accumulator and flags, advanced from the opcode meaning only
	logic [7:0] m_acc = ACC_RST;
	logic m_c = 1'b0;
	logic m_dc = 1'b0;
	logic m_z = 1'b0;

	// Clock at 100 MHz
	always #5 mclk = ~mclk;

	exec_core uut (.mclk(mclk), .arst_n(arst_n), .insn_valid(insn_valid), .insn(insn),
		.file_rdata(file_rdata), .stack_top(stack_top), .file_addr(file_addr),
		.file_we(file_we), .file_wdata(file_wdata), .acc(acc), .carry_flag(carry_flag),
		.nibble_wrap_flag(nibble_wrap_flag), .zero_flag(zero_flag),
		.timeout_flag(timeout_flag), .sleep_entered_flag(sleep_entered_flag),
		.stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value), .busy(busy),
		.halted(halted), .watchdog_clear(watchdog_clear));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [12:0] seen, input logic [12:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (mismatches == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// One word for one cycle; returns at the falling edge where results are visible
	task automatic issue(input logic [13:0] w, input logic [7:0] rd);
		@(negedge mclk);
		insn = w;
		insn_valid = 1'b1;
		file_rdata = rd;
		@(negedge mclk);
		insn_valid = 1'b0;
	endtask

	// Accumulator and flags against the bench copy
	task automatic state_ok();
		chk("acc", 13'(acc), 13'(m_acc));
		chk("carry", 13'(carry_flag), 13'(m_c));
		chk("nibble_wrap", 13'(nibble_wrap_flag), 13'(m_dc));
		chk("zero", 13'(zero_flag), 13'(m_z));
	endtask

	// Works out the expected result, issues the word and compares
	task automatic run(input logic [13:0] w, input logic [7:0] rd);
		logic [7:0] res, opa;
		logic is_f, to_file, is_sub;
		is_f = (w[13:12] == 2'b00) && (w[13:8] != OPC_STORE);
		to_file = (w[13:7] == 7'h01) || (is_f && w[7]);
		is_sub = (w[13:9] == 5'h1e) || (w[13:8] == OPC_SUB_F);
		opa = is_f ? rd : w[7:0];
		res = m_acc;
		casez (w[13:8])
			6'b110???: res = w[7:0];
			6'b11110?: res = opa - m_acc;
			OPC_OR_LIT, OPC_OR_F: res = m_acc | opa;
			OPC_XOR_LIT, OPC_XOR_F: res = m_acc ^ opa;
			OPC_SUB_F: res = opa - m_acc;
			OPC_RRF: res = {m_c, rd[7:1]};
			OPC_RLF: res = {rd[6:0], m_c};
			OPC_SWAP: res = {rd[3:0], rd[7:4]};
			default: ;
		endcase
		if (is_sub) begin
			m_c = (opa >= m_acc);
			m_dc = (opa[3:0] >= m_acc[3:0]);
		end
		if (w[13:8] == OPC_RRF) m_c = rd[0];
		if (w[13:8] == OPC_RLF) m_c = rd[7];
		if (is_sub || w[13:8] inside {OPC_OR_LIT, OPC_XOR_LIT, OPC_OR_F, OPC_XOR_F}) m_z = (res == 8'h00);
		if (w[13:12] == 2'b11 || (is_f && !w[7])) m_acc = res;
		issue(w, rd);
		state_ok();
		chk("file_we", 13'(file_we), 13'(to_file));
		if (to_file) begin
			chk("file_wdata", 13'(file_wdata), 13'(w[13:7] == 7'h01 ? m_acc : res));
			chk("file_addr", 13'(file_addr), 13'(w[6:0]));
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_literals();
		run({6'h33, 8'h5a}, 8'h00);
		run({OPC_OR_LIT, 8'h81}, 8'h00);
		run({OPC_XOR_LIT, 8'hdb}, 8'h00);
		run({6'h30, 8'h0f}, 8'h00);
		run({OPC_OR_LIT, 8'h00}, 8'h00);
		run({6'h39, 8'hf0}, 8'h00);
	endtask

	task automatic t_file();
		run({OPC_OR_F, 1'b0, 7'h15}, 8'h30);
		run({OPC_OR_F, 1'b1, 7'h7f}, 8'h40);
		run({OPC_XOR_F, 1'b1, 7'h00}, 8'h3f);
		run({OPC_XOR_F, 1'b0, 7'h22}, 8'hff);
		run({OPC_STORE, 1'b1, 7'h41}, 8'h00);
		run(14'h0000, 8'h5a);
	endtask

	task automatic t_rotate();
		run({OPC_RLF, 1'b0, 7'h10}, 8'he6);
		run({OPC_RRF, 1'b1, 7'h11}, 8'h02);
		run({OPC_RRF, 1'b0, 7'h11}, 8'h01);
		run({OPC_RLF, 1'b1, 7'h12}, 8'h00);
		run({OPC_SWAP, 1'b0, 7'h12}, 8'ha5);
		run({OPC_SWAP, 1'b1, 7'h13}, 8'h0f);
	endtask

	// Borrow and no-borrow cases, from both the whole byte and the low nibble
	task automatic t_subtract();
		run({OPC_SUB_LIT, 8'h5a}, 8'h00);
		run({6'h30, 8'h01}, 8'h00);
		run({6'h3d, 8'h00}, 8'h00);
		run({6'h30, 8'h18}, 8'h00);
		run({OPC_SUB_F, 1'b1, 7'h20}, 8'h21);
		run({OPC_SUB_F, 1'b0, 7'h21}, 8'h09);
	endtask

	// Return, then a word in the dead cycle that must be dropped, then one taken
	task automatic t_return();
		stack_top = 13'h1abc;
		@(negedge mclk);
		insn = OPC_RETURN;
		insn_valid = 1'b1;
		@(negedge mclk);
		chk("pc_value", pc_value, 13'h1abc);
		chk("pops", 13'({stack_pop, pc_load, busy}), 13'h7);
		insn = {6'h30, 8'h11};
		@(negedge mclk);
		state_ok();
		chk("busy", 13'({busy, pc_load}), 13'h0);
		insn = {6'h30, 8'h22};
		@(negedge mclk);
		insn_valid = 1'b0;
		m_acc = 8'h22;
		chk("acc", 13'(acc), 13'(m_acc));
		stack_top = 13'h0123;
		run({6'h37, 8'h3c}, 8'h00);
		chk("pc_value", pc_value, 13'h0123);
		chk("pops", 13'({stack_pop, pc_load, busy}), 13'h7);
	endtask

	// Low-power entry, refusal while halted, and recovery only through reset
	task automatic t_sleep();
		chk("sleep_entered", 13'(sleep_entered_flag), 13'h1);
		issue(OPC_SLEEP, 8'h00);
		chk("wd_clear", 13'(watchdog_clear), 13'h1);
		chk("timeout", 13'(timeout_flag), 13'h1);
		chk("sleep_entered", 13'(sleep_entered_flag), 13'h0);
		chk("halted", 13'(halted), 13'h1);
		issue({6'h30, 8'h77}, 8'h00);
		state_ok();
		chk("wd_clear", 13'({watchdog_clear, halted}), 13'h1);
		arst_n = 1'b0;
		@(negedge mclk);
		chk("halted", 13'({halted, timeout_flag, sleep_entered_flag}), 13'h3);
		arst_n = 1'b1;
		m_acc = ACC_RST;
		m_c = 1'b0;
		m_dc = 1'b0;
		m_z = 1'b0;
		state_ok();
		run({6'h30, 8'h77}, 8'h00);
		chk("halted", 13'(halted), 13'h0);
	endtask

	// ----------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------
	initial begin
		repeat (6) @(negedge mclk);
		arst_n = 1'b1;
		state_ok();
		t_literals();
		t_file();
		t_rotate();
		t_subtract();
		t_return();
		t_sleep();
		stop_test();
	end

	// The whole run needs under a hundred cycles; far beyond that means a hang
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			stop_test();
		end
	end
endmodule
